// ===== hw/fpdp_core.sv
/*
  floating-point add, subtract, multiply and divide datapath with its
  register port and sequencer.
  assumes the register port is driven on ref_clk_i and waits for busy low.
*/
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module fpdp_core
  import fpdp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic busy_o
);

  fpdp_reg_t s_q;
  fpdp_reg_t s_d;

  logic [EXP_W:0] diff;
  logic [EXP_W:0] absd;
  logic diff_neg;
  logic src_sign_eff;
  logic [FRAC_W-1:0] fa;
  logic [FRAC_W-1:0] fb;
  logic [FRAC_W-1:0] dmag;
  logic [FRAC_W-1:0] smag;
  logic [FRAC_W-1:0] dm;
  logic [FRAC_W-1:0] p;
  logic [FRAC_W-1:0] msum;
  logic [FRAC_W+1:0] ydiv;
  logic [FRAC_W+1:0] nr;

  always_comb
  begin
    s_d = s_q;
    diff = {1'b0, s_q.result_exponent_reg} - {1'b0, s_q.source_exponent_reg};
    diff_neg = diff[EXP_W];
    absd = diff_neg ? (~diff + 11'h001) : diff;
    src_sign_eff = s_q.ssign ^ (s_q.op == FPDP_OP_SUB);
    fa = {2'b01, s_q.dfrac};
    fb = {2'b01, s_q.sfrac};
    dmag = (s_q.op == FPDP_OP_SUB) ? s_q.scratch_b_partial_result : s_q.scratch_a[FRAC_W-1:0];
    smag = (s_q.op == FPDP_OP_SUB) ? s_q.scratch_a[FRAC_W-1:0] : s_q.scratch_b_partial_result;
    dm = dmag - smag;
    p = s_q.scratch_b_partial_result;
    msum = s_q.q[0] ? (p + s_q.scratch_a[FRAC_W-1:0]) : p;
    ydiv = {2'b00, s_q.scratch_b_partial_result};
    nr = s_q.scratch_a[FRAC_W+1] ? (s_q.scratch_a + ydiv) : (s_q.scratch_a - ydiv);

    // register writes only while idle
    if (wr_i && s_q.state == FPDP_IDLE)
    begin
      unique case (addr_i)
        REG_CTRL:
        begin
          s_d.op = fpdp_op_t'(wdata_i[CTRL_OP_MSB:CTRL_OP_LSB]);
          s_d.dbl = wdata_i[CTRL_DBL_BIT];
          s_d.truncate_select_bit = wdata_i[CTRL_TRUNC_BIT];
          if (wdata_i[CTRL_START_BIT])
          begin
            s_d.state = FPDP_SETUP;
          end
        end
        REG_DEXP:
        begin
          s_d.result_exponent_reg = wdata_i[EXP_W-1:0];
          s_d.dsign = wdata_i[SIGN_BIT];
        end
        REG_SEXP:
        begin
          s_d.source_exponent_reg = wdata_i[EXP_W-1:0];
          s_d.ssign = wdata_i[SIGN_BIT];
        end
        REG_DFRAC: s_d.dfrac = wdata_i[MANT_W-1:0];
        REG_SFRAC: s_d.sfrac = wdata_i[MANT_W-1:0];
        default: s_d.state = s_q.state;
      endcase
    end

    unique case (s_q.state)
      FPDP_IDLE: s_d.rounded = s_q.rounded;
      FPDP_SETUP:
      begin
        s_d.rounded = 1'b0;
        s_d.zero_res = 1'b0;
        s_d.nright = '0;
        s_d.nleft = '0;
        s_d.sign_scratch = s_q.dsign ^ s_q.ssign;
        s_d.q = s_q.dbl ? (fb >> (GUARD_BIT - LOOP_CNT_DP)) : (fb >> (GUARD_BIT - LOOP_CNT_SP));
        s_d.scratch_a = {2'b00, fa};
        s_d.scratch_b_partial_result = '0;
        s_d.cnt = s_q.dbl ? LOOP_CNT_DP : LOOP_CNT_SP;
        if (s_q.op == FPDP_OP_MUL)
        begin
          s_d.rexp = s_q.source_exponent_reg + s_q.result_exponent_reg - EXP_BIAS;
          s_d.state = FPDP_MLOOP;
        end
        else if (s_q.op == FPDP_OP_DIV)
        begin
          s_d.rexp = s_q.result_exponent_reg - s_q.source_exponent_reg + EXP_BIAS;
          s_d.scratch_b_partial_result = fb;
          s_d.q = '0;
          s_d.state = FPDP_DLOOP;
        end
        else
        begin
          s_d.exp_diff_scratch = diff;
          s_d.zero_branch_flag = (diff == '0);
          s_d.eff_sub = (s_q.op == FPDP_OP_SUB) ^ s_q.dsign ^ s_q.ssign;
          s_d.rexp = diff_neg ? s_q.source_exponent_reg : s_q.result_exponent_reg;
          s_d.align_exp = diff_neg ? s_q.result_exponent_reg : s_q.source_exponent_reg;
          s_d.sign_scratch = s_q.dsign;
          s_d.shift_a = diff_neg ^ (s_q.op == FPDP_OP_SUB);
          s_d.cnt = absd[CNT_W-1:0];
          if (s_q.op == FPDP_OP_SUB)
          begin
            s_d.scratch_a = {2'b00, fb};
            s_d.scratch_b_partial_result = fa;
          end
          else
          begin
            s_d.scratch_a = {2'b00, fa};
            s_d.scratch_b_partial_result = fb;
          end
          if (absd > (s_q.dbl ? ALIGN_MAX_DP : ALIGN_MAX_SP))
          begin
            s_d.scratch_b_partial_result = diff_neg ? fb : fa;
            s_d.sign_scratch = diff_neg ? src_sign_eff : s_q.dsign;
            s_d.state = FPDP_DONE;
          end
          else if (diff == '0)
          begin
            s_d.state = FPDP_ARITH;
          end
          else
          begin
            s_d.state = FPDP_ALIGN;
          end
        end
      end
      FPDP_ALIGN:
      begin
        if (s_q.cnt == '0)
        begin
          s_d.state = FPDP_ARITH;
        end
        else
        begin
          s_d.cnt = s_q.cnt - 7'h01;
          s_d.align_exp = s_q.align_exp + 10'h001;
          if (s_q.shift_a)
          begin
            s_d.scratch_a = s_q.scratch_a >> 1;
          end
          else
          begin
            s_d.scratch_b_partial_result = p >> 1;
          end
        end
      end
      FPDP_ARITH:
      begin
        s_d.state = FPDP_NORM;
        if (!s_q.eff_sub)
        begin
          s_d.scratch_b_partial_result = dmag + smag;
        end
        else if (s_q.zero_branch_flag)
        begin
          s_d.scratch_b_partial_result = dm;
          s_d.state = FPDP_ZTEST;
        end
        else if (dm[GUARD_BIT])
        begin
          s_d.scratch_b_partial_result = ~dm + 60'h1;
          s_d.sign_scratch = src_sign_eff;
        end
        else
        begin
          s_d.scratch_b_partial_result = dm;
        end
      end
      FPDP_ZTEST:
      begin
        if (p[GUARD_BIT])
        begin
          s_d.scratch_b_partial_result = ~p + 60'h1;
          s_d.sign_scratch = src_sign_eff;
          s_d.state = FPDP_NORM;
        end
        else
        begin
          s_d.scratch_b_partial_result = p - 60'h1;
          s_d.state = FPDP_ZFIX;
        end
      end
      FPDP_ZFIX:
      begin
        if (p[GUARD_BIT])
        begin
          s_d.scratch_b_partial_result = '0;
          s_d.zero_res = 1'b1;
          s_d.rexp = '0;
          s_d.sign_scratch = 1'b0;
          s_d.state = FPDP_DONE;
        end
        else
        begin
          s_d.scratch_b_partial_result = p + 60'h1;
          s_d.state = FPDP_NORM;
        end
      end
      FPDP_NORM:
      begin
        if (p == '0)
        begin
          s_d.zero_res = 1'b1;
          s_d.rexp = '0;
          s_d.state = FPDP_DONE;
        end
        else if (p[GUARD_BIT])
        begin
          s_d.scratch_b_partial_result = p >> 1;
          s_d.rexp = s_q.rexp + 10'h001;
          s_d.nright = s_q.nright + 7'h01;
        end
        else if (!p[HIDDEN_BIT])
        begin
          s_d.scratch_b_partial_result = p << 1;
          s_d.rexp = s_q.rexp - 10'h001;
          s_d.nleft = s_q.nleft + 7'h01;
        end
        else if (s_q.truncate_select_bit || s_q.rounded)
        begin
          s_d.state = FPDP_DONE;
        end
        else
        begin
          s_d.state = FPDP_ROUND;
        end
      end
      FPDP_ROUND:
      begin
        s_d.scratch_b_partial_result = p + (s_q.dbl ? RND_ADD_DP : RND_ADD_SP);
        s_d.rounded = 1'b1;
        s_d.state = FPDP_NORM;
      end
      FPDP_MLOOP:
      begin
        if (s_q.cnt == '0)
        begin
          s_d.state = FPDP_NORM;
        end
        else
        begin
          s_d.scratch_b_partial_result = msum >> 1;
          s_d.q = {msum[0], s_q.q[FRAC_W-1:1]};
          s_d.cnt = s_q.cnt - 7'h01;
        end
      end
      FPDP_DLOOP:
      begin
        if (s_q.cnt == '0)
        begin
          s_d.scratch_b_partial_result = s_q.q;
          s_d.state = FPDP_NORM;
        end
        else
        begin
          s_d.scratch_a = {nr[FRAC_W:0], 1'b0};
          s_d.q = {s_q.q[FRAC_W-2:0], ~nr[FRAC_W+1]};
          s_d.cnt = s_q.cnt - 7'h01;
        end
      end
      FPDP_DONE: s_d.state = FPDP_IDLE;
      default: s_d.state = FPDP_IDLE;
    endcase

    // read data in the cycle after the strobe
    s_d.rdata = '0;
    if (rd_i)
    begin
      unique case (addr_i)
        REG_CTRL:
        begin
          s_d.rdata[CTRL_OP_MSB:CTRL_OP_LSB] = s_q.op;
          s_d.rdata[CTRL_DBL_BIT] = s_q.dbl;
          s_d.rdata[CTRL_TRUNC_BIT] = s_q.truncate_select_bit;
        end
        REG_DEXP: s_d.rdata[SIGN_BIT:0] = {s_q.dsign, s_q.result_exponent_reg};
        REG_SEXP: s_d.rdata[SIGN_BIT:0] = {s_q.ssign, s_q.source_exponent_reg};
        REG_DFRAC: s_d.rdata[MANT_W-1:0] = s_q.dfrac;
        REG_SFRAC: s_d.rdata[MANT_W-1:0] = s_q.sfrac;
        REG_RFRAC: s_d.rdata[FRAC_W-1:0] = s_q.scratch_b_partial_result;
        REG_RSTAT:
        begin
          s_d.rdata[EXP_W-1:0] = s_q.rexp;
          s_d.rdata[SIGN_BIT] = s_q.sign_scratch;
          s_d.rdata[STAT_ZERO_BIT] = s_q.zero_res;
          s_d.rdata[STAT_BUSY_BIT] = (s_q.state != FPDP_IDLE);
        end
        REG_EXPDIFF: s_d.rdata[EXP_W:0] = s_q.exp_diff_scratch;
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s_q <= '0;
    end
    else if (ce_i)
    begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign busy_o = (s_q.state != FPDP_IDLE);

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  a_align_step: assert property (
    ce_i && s_q.state == FPDP_ALIGN && s_q.cnt != '0
    |=> s_q.align_exp == $past(s_q.align_exp) + 10'h001 && s_q.cnt == $past(s_q.cnt) - 7'h01)
    else $error("alignment step did not raise exponent");

  a_result_exp_max: assert property (
    ce_i && s_q.state == FPDP_SETUP && s_q.op inside {FPDP_OP_ADD, FPDP_OP_SUB}
    |=> s_q.rexp == ((s_q.result_exponent_reg > s_q.source_exponent_reg) ?
                     s_q.result_exponent_reg : s_q.source_exponent_reg))
    else $error("result exponent is not the larger exponent");

  a_done_normal: assert property (
    s_q.state == FPDP_DONE && !s_q.zero_res
    |-> s_q.scratch_b_partial_result[GUARD_BIT:HIDDEN_BIT] == 2'b01)
    else $error("stored fraction not normalized");

  a_left_norm: assert property (
    ce_i && s_q.state == FPDP_NORM && p != '0 && p[GUARD_BIT:HIDDEN_BIT] == 2'b00
    |=> s_q.scratch_b_partial_result == ($past(p) << 1) && s_q.rexp == $past(s_q.rexp) - 10'h001
        && s_q.nleft == $past(s_q.nleft) + 7'h01)
    else $error("left normalize step wrong");

  a_round_bit: assert property (
    ce_i && s_q.state == FPDP_ROUND
    |=> s_q.scratch_b_partial_result == $past(p) + ($past(s_q.dbl) ? RND_ADD_DP : RND_ADD_SP)
        && s_q.state == FPDP_NORM)
    else $error("round increment wrong");

  a_trunc_store: assert property (
    ce_i && s_q.state == FPDP_NORM && p[GUARD_BIT:HIDDEN_BIT] == 2'b01 && s_q.truncate_select_bit
    |=> s_q.state == FPDP_DONE ##1 (s_q.state == FPDP_IDLE || !$past(ce_i)))
    else $error("truncate mode did not store directly");

  a_round_ovf: assert property (
    ce_i && s_q.state == FPDP_NORM && p[GUARD_BIT]
    |=> s_q.scratch_b_partial_result == ($past(p) >> 1) && s_q.rexp == $past(s_q.rexp) + 10'h001)
    else $error("overflow not shifted back");

  a_zero_store: assert property (
    ce_i && s_q.state == FPDP_ZFIX && p[GUARD_BIT]
    |=> s_q.scratch_b_partial_result == '0 && s_q.zero_res && s_q.state == FPDP_DONE)
    else $error("zero difference not stored as zero");

  a_mul_exp: assert property (
    ce_i && s_q.state == FPDP_SETUP && s_q.op == FPDP_OP_MUL
    |=> s_q.rexp == $past(s_q.source_exponent_reg) + $past(s_q.result_exponent_reg) - EXP_BIAS
        && s_q.scratch_b_partial_result == '0 && s_q.state == FPDP_MLOOP)
    else $error("multiply setup wrong");

  a_mul_loop: assert property (
    ce_i && s_q.state == FPDP_MLOOP && s_q.cnt != '0
    |=> s_q.scratch_b_partial_result == ($past(msum) >> 1) && s_q.cnt == $past(s_q.cnt) - 7'h01)
    else $error("multiply step wrong");

  a_busy_hold: assert property (
    s_q.state != FPDP_IDLE && wr_i |=> $stable(s_q.op) && $stable(s_q.dfrac) && $stable(s_q.sfrac))
    else $error("write accepted while busy");

  c_mul_done: cover property (s_q.state == FPDP_MLOOP ##[1:80] s_q.state == FPDP_DONE);
  c_div_done: cover property (s_q.state == FPDP_DLOOP ##[1:80] s_q.state == FPDP_DONE);
  c_zero_res: cover property (s_q.state == FPDP_ZFIX ##1 s_q.zero_res);
  c_round_ovf: cover property (s_q.state == FPDP_ROUND ##1 p[GUARD_BIT]);

endmodule // fpdp_core
`default_nettype wire

// ===== include/fpdp_pkg.sv
/*
  constants, register map, states and state record of the floating-point
  add/multiply/divide datapath.
  assumes one clock domain and a plain register port driven on the same clock.
*/
// Behaviour
// - align by right-shifting the smaller-exponent fraction, raising its exponent per shift
// - add/subtract result exponent is the larger operand exponent
// - stored fraction is normalized: bit 59 zero, bit 58 one
// - left-shift a nonzero fraction until normalized, decrementing exponent each shift
// - round mode adds one at bit 34 single or bit 02 double
// - truncate mode with shift in range stores the shifted result directly
// - rounding overflow into bit 59 is shifted back by the normalizer
// - count normalize shifts and adjust the result exponent directly
// - addition: exponent difference dest minus source, dest in A, source in B
// - subtraction: source in A, dest in B, compute B minus A
// - negative difference: complement negative result, take source sign
// - zero exponent difference flagged after subtract; no fraction is shifted
// - unshifted difference with bit 59 set is negated to sign-magnitude
// - unshifted positive difference: decrement, zero if bit 59 sets, else restore
// - positive difference: shift source, subtract, normalize at once
// - multiply exponent is source plus accumulator exponent minus bias 200
// - multiply setup: hidden bits, multiplier to Q, sign saved, partial cleared
// - multiply loop adds on multiplier LSB, shifts right, counts 56 or 24
// - divide nonrestoring: dividend in A, divisor in B, quotient in Q
// - divide exponent difference plus bias 200, hidden bits, sign saved
// - alignment beyond 25 single or 57 double delivers the unshifted operand
// - round or truncate follows the truncate select bit
package fpdp_pkg;

  localparam int FRAC_W = 60;
  localparam int MANT_W = 58;
  localparam int EXP_W = 10;
  localparam int DATA_W = 64;
  localparam int ADDR_W = 4;
  localparam int CNT_W = 7;
  localparam int GUARD_BIT = 59;
  localparam int HIDDEN_BIT = 58;

  // bias is 200 octal
  localparam logic [EXP_W-1:0] EXP_BIAS = 10'h080;
  // round increments: bit 34 and bit 2
  localparam logic [FRAC_W-1:0] RND_ADD_SP = 60'h000_0004_0000_0000;
  localparam logic [FRAC_W-1:0] RND_ADD_DP = 60'h000_0000_0000_0004;
  // alignment limits 25 and 57
  localparam logic [EXP_W:0] ALIGN_MAX_SP = 11'h019;
  localparam logic [EXP_W:0] ALIGN_MAX_DP = 11'h039;
  // loop counts 24 and 56
  localparam logic [CNT_W-1:0] LOOP_CNT_SP = 7'h18;
  localparam logic [CNT_W-1:0] LOOP_CNT_DP = 7'h38;

  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_DEXP = 4'h1;
  localparam logic [ADDR_W-1:0] REG_SEXP = 4'h2;
  localparam logic [ADDR_W-1:0] REG_DFRAC = 4'h3;
  localparam logic [ADDR_W-1:0] REG_SFRAC = 4'h4;
  localparam logic [ADDR_W-1:0] REG_RFRAC = 4'h5;
  localparam logic [ADDR_W-1:0] REG_RSTAT = 4'h6;
  localparam logic [ADDR_W-1:0] REG_EXPDIFF = 4'h7;

  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_MSB = 1;
  localparam int CTRL_DBL_BIT = 2;
  localparam int CTRL_TRUNC_BIT = 3;
  localparam int CTRL_START_BIT = 4;
  localparam int SIGN_BIT = 10;
  localparam int STAT_ZERO_BIT = 11;
  localparam int STAT_BUSY_BIT = 12;

  typedef enum logic [1:0] {
    FPDP_OP_ADD = 2'h0,
    FPDP_OP_SUB = 2'h1,
    FPDP_OP_MUL = 2'h2,
    FPDP_OP_DIV = 2'h3
  } fpdp_op_t;

  typedef enum logic [3:0] {
    FPDP_IDLE = 4'h0,
    FPDP_SETUP = 4'h1,
    FPDP_ALIGN = 4'h3,
    FPDP_ARITH = 4'h2,
    FPDP_ZTEST = 4'h6,
    FPDP_ZFIX = 4'he,
    FPDP_NORM = 4'h7,
    FPDP_ROUND = 4'h5,
    FPDP_DONE = 4'h4,
    FPDP_MLOOP = 4'hc,
    FPDP_DLOOP = 4'hd
  } fpdp_state_t;

  typedef struct packed {
    fpdp_state_t state;
    fpdp_op_t op;
    logic dbl;
    logic truncate_select_bit;
    logic dsign;
    logic ssign;
    logic [EXP_W-1:0] result_exponent_reg;
    logic [EXP_W-1:0] source_exponent_reg;
    logic [MANT_W-1:0] dfrac;
    logic [MANT_W-1:0] sfrac;
    logic sign_scratch;
    logic [FRAC_W+1:0] scratch_a;
    logic [FRAC_W-1:0] scratch_b_partial_result;
    logic [FRAC_W-1:0] q;
    logic [EXP_W:0] exp_diff_scratch;
    logic [EXP_W-1:0] rexp;
    logic [EXP_W-1:0] align_exp;
    logic [CNT_W-1:0] cnt;
    logic zero_branch_flag;
    logic eff_sub;
    logic shift_a;
    logic rounded;
    logic zero_res;
    logic [CNT_W-1:0] nright;
    logic [CNT_W-1:0] nleft;
    logic [DATA_W-1:0] rdata;
  } fpdp_reg_t;

endpackage

// ===== test/fpdp_host_model.sv
/*
  host sequencer model: issues register requests one at a time.
  assumes the datapath samples strobes on the rising edge of ref_clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module fpdp_host_model
  import fpdp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [DATA_W-1:0] rdata_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial
  begin
    addr_o = '0;
    wdata_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // released write data carries the inverse of the last value
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge ref_clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask

  // no result read and no new start until busy drops
  task automatic wait_idle(output logic ok);
    logic [DATA_W-1:0] s;
    ok = 1'b0;
    for (int n = 0; n < 400 && ok !== 1'b1; n++)
    begin
      rd(REG_RSTAT, s);
      ok = ~s[STAT_BUSY_BIT];
    end
  endtask
endmodule // fpdp_host_model
`default_nettype wire

// ===== test/testbench.sv
/*
  self-checking bench: random and corner add/sub cases against a reference,
  multiply and divide exponent relations, register port checks.
  assumes the host model drives the register port on ref_clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench
  import fpdp_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic wr;
  logic rd;
  logic busy;
  int bad_count = 0;
  int tests_run = 0;
  logic stall = 1'b0;
  integer seed = 6809;

  always #4 ref_clk_i = ~ref_clk_i;

  fpdp_core dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .busy_o(busy));
  fpdp_host_model host_u (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // expected {zero, sign, exponent, fraction} of an add or subtract
  function automatic logic [71:0] ref_as(logic sub_op, logic dbl, logic trunc, logic ds,
    logic ss, logic [9:0] de, logic [9:0] se, logic [57:0] df, logic [57:0] sf);
    logic [59:0] a;
    logic [59:0] b;
    logic [59:0] r;
    logic [9:0] e;
    logic es;
    logic neg;
    a = {2'b01, df};
    b = {2'b01, sf};
    es = sub_op ^ ds ^ ss;
    if ((de >= se ? de - se : se - de) > (dbl ? 57 : 25))
      return (de >= se) ? {1'b0, ds, de, a} : {1'b0, ss ^ sub_op, se, b};
    e = (de >= se) ? de : se;
    if (de >= se)
      b = b >> (de - se);
    else
      a = a >> (se - de);
    neg = es && b > a;
    r = !es ? a + b : (neg ? b - a : a - b);
    if (r == 60'h0)
      return {1'b1, 71'h0};
    if (r[59])
    begin
      r = r >> 1;
      e = e + 10'h001;
    end
    while (r[58] == 1'b0)
    begin
      r = r << 1;
      e = e - 10'h001;
    end
    if (!trunc)
      r = r + (dbl ? RND_ADD_DP : RND_ADD_SP);
    if (r[59])
    begin
      r = r >> 1;
      e = e + 10'h001;
    end
    return {1'b0, neg ? ss ^ sub_op : ds, e, r};
  endfunction

  task automatic do_op(input logic [1:0] op, input logic dbl, input logic trunc,
    input logic ds, input logic ss, input logic [9:0] de, input logic [9:0] se,
    input logic [57:0] df, input logic [57:0] sf, output logic [71:0] got);
    logic [DATA_W-1:0] f;
    logic [DATA_W-1:0] s;
    logic ok;
    host_u.wr(REG_DEXP, {53'h0, ds, de});
    host_u.wr(REG_SEXP, {53'h0, ss, se});
    host_u.wr(REG_DFRAC, {6'h0, df});
    host_u.wr(REG_SFRAC, {6'h0, sf});
    host_u.wr(REG_CTRL, {59'h0, 1'b1, trunc, dbl, op});
    // frozen clock enable must hold the operation busy
    if (stall)
    begin
      ce_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      ce_i <= 1'b1;
      check({71'h0, busy}, 72'h1);
    end
    host_u.wr(REG_CTRL, {59'h0, 1'b1, 4'h0});
    host_u.wait_idle(ok);
    if (ok !== 1'b1)
    begin
      check(72'h0, 72'h1);
      print_verdict();
    end
    host_u.rd(REG_RFRAC, f);
    host_u.rd(REG_RSTAT, s);
    got = {s[11:0], f[59:0]};
  endtask

  task automatic tcase(input logic [1:0] op, input logic dbl, input logic trunc,
    input logic ds, input logic ss, input logic [9:0] de, input logic [9:0] se,
    input logic [57:0] df, input logic [57:0] sf);
    logic [71:0] got;
    logic [DATA_W-1:0] x;
    do_op(op, dbl, trunc, ds, ss, de, se, df, sf, got);
    check(got, ref_as(op[0], dbl, trunc, ds, ss, de, se, df, sf));
    host_u.rd(REG_EXPDIFF, x);
    check({61'h0, x[10:0]}, {61'h0, {1'b0, de} - {1'b0, se}});
  endtask

  initial
  begin : main
    logic [71:0] g0, g1, g2;
    logic [DATA_W-1:0] x;
    logic [57:0] df, sf, m;
    logic [9:0] de, se;
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    host_u.rd(REG_RSTAT, x);
    check({8'h0, x}, 72'h0);
    for (int i = 8; i < 16; i++)
    begin
      host_u.wr(4'(i), 64'h5a5a);
      host_u.rd(4'(i), x);
      check({8'h0, x}, 72'h0);
    end
    host_u.wr(REG_CTRL, 64'h0e);
    host_u.rd(REG_CTRL, x);
    check({8'h0, x}, 72'h0e);
    for (int i = 0; i < 40; i++)
    begin
      m = i[0] ? ~58'hfff : ~58'hff_ffff_ffff;
      df = 58'({$random(seed), $random(seed)}) & m;
      sf = (i % 8 == 3) ? df : 58'({$random(seed), $random(seed)}) & m;
      de = 10'h100 + 10'($random(seed) & 255);
      se = (i % 8 == 3) ? de : de + 10'($random(seed) & 15) - 10'h008;
      tcase(2'($random(seed) & 1), i[0], 1'($random(seed)), 1'($random(seed)),
        1'($random(seed)), de, se, df, sf);
    end
    tcase(FPDP_OP_ADD, 1'b1, 1'b0, 1'b0, 1'b0, 10'h200, 10'h1c7, 58'h3ff_ffff_ffff_fffc,
      58'h0);
    stall = 1'b1;
    tcase(FPDP_OP_ADD, 1'b0, 1'b1, 1'b0, 1'b1, 10'h200, 10'h1e6, df, sf);
    stall = 1'b0;
    tcase(FPDP_OP_SUB, 1'b1, 1'b1, 1'b0, 1'b0, 10'h180, 10'h180, 58'h1000, 58'h2000);
    tcase(FPDP_OP_SUB, 1'b1, 1'b0, 1'b1, 1'b1, 10'h180, 10'h180, df, df);
    do_op(FPDP_OP_MUL, 1'b1, 1'b1, 1'b0, 1'b1, 10'h180, 10'h170, df, sf, g0);
    do_op(FPDP_OP_MUL, 1'b1, 1'b1, 1'b0, 1'b1, 10'h180, 10'h171, df, sf, g1);
    check({62'h0, g1[69:60] - g0[69:60]}, 72'h1);
    check({70'h0, g1[59:58]}, 72'h1);
    check({71'h0, g0[70]}, 72'h1);
    for (int p = 0; p < 2; p++)
    begin
      do_op(FPDP_OP_MUL, p[0], 1'b1, 1'b0, 1'b0, 10'h180, 10'h180, 58'h0, 58'h0, g2);
      check({12'h0, g2[59:0]}, {12'h0, 60'h400_0000_0000_0000});
    end
    do_op(FPDP_OP_DIV, 1'b1, 1'b1, 1'b0, 1'b0, 10'h180, 10'h170, df, sf, g0);
    do_op(FPDP_OP_DIV, 1'b1, 1'b1, 1'b0, 1'b0, 10'h181, 10'h170, df, sf, g1);
    do_op(FPDP_OP_DIV, 1'b1, 1'b1, 1'b0, 1'b0, 10'h180, 10'h171, df, sf, g2);
    check({62'h0, g1[69:60] - g0[69:60]}, 72'h1);
    check({62'h0, g0[69:60] - g2[69:60]}, 72'h1);
    check({70'h0, g0[59:58]}, 72'h1);
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    host_u.rd(REG_RFRAC, x);
    check({8'h0, x}, 72'h0);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
